// ---- core/gsr_pkg.sv ----
// Function
// - overvoltage flag follows cell threshold comparison
// - inaccurate flag: reset or count above 64
// - qualified flag follows discharge qualification
// - end-of-discharge latched until valid charge
// - calibration done flag after completed calibration
// - temperature reported as signed whole degrees
// - discharge rate encoded as three-bit code
// - overload flag compares rate against threshold
// - pin levels stored as supply fractions
// - charge actions counted, restart on update
// - override bits drive LEDs when enable low outside calibration
// - full charge tally advances per sixteen
// - command 0x78 resets capacity, count and tally registers
// - command 0x68 starts offset calibration
// - command 0x60 ends running calibration
// - calibration self-starts on trickle, power-up, full
// - design capacity taken from select pin
// - voltages as 16-bit, low byte first
// - discharge tally accumulates, 256 counts per unit
// - charge rate encoded as two-bit code
// - valid charge after two capacity increments
// - remaining capacity kept rate/temperature compensated
// - command byte: direction top, address below
// - writes to absent addresses are discarded
// - charging flag set on charge, cleared discharge
// - full reset indicator set on full reset
package gsr_pkg;
	// register addresses
	localparam logic [6:0] ADDR_STAT1  = 7'h01;
	localparam logic [6:0] ADDR_TEMP   = 7'h02;
	localparam logic [6:0] ADDR_NAC    = 7'h03;
	localparam logic [6:0] ADDR_LMD    = 7'h05;
	localparam logic [6:0] ADDR_STAT2  = 7'h06;
	localparam logic [6:0] ADDR_CSEL   = 7'h07;
	localparam logic [6:0] ADDR_OPT    = 7'h08;
	localparam logic [6:0] ADDR_CACT   = 7'h09;
	localparam logic [6:0] ADDR_LEDCTL = 7'h0a;
	localparam logic [6:0] ADDR_FTALLY = 7'h0b;
	localparam logic [6:0] ADDR_CMD    = 7'h0c;
	localparam logic [6:0] ADDR_DCAP   = 7'h0f;
	localparam logic [6:0] ADDR_VBATL  = 7'h10;
	localparam logic [6:0] ADDR_VBATH  = 7'h11;
	localparam logic [6:0] ADDR_VSNSL  = 7'h12;
	localparam logic [6:0] ADDR_VSNSH  = 7'h13;
	localparam logic [6:0] ADDR_VTHL   = 7'h14;
	localparam logic [6:0] ADDR_VTHH   = 7'h15;
	localparam logic [6:0] ADDR_DTALLY = 7'h18;
	localparam logic [6:0] ADDR_STAT3  = 7'h4c;
	// command byte layout
	localparam int CMD_DIR_BIT = 7;
	// command word codes
	localparam logic [7:0] CMD_FULL_RESET = 8'h78;
	localparam logic [7:0] CMD_CAL_START  = 8'h68;
	localparam logic [7:0] CMD_CAL_STOP   = 8'h60;
	// led control field
	localparam int         LED_EN_BIT    = 0;
	localparam logic [7:0] LED_CTL_MASK  = 8'h3f;
	localparam logic [7:0] LED_CTL_RESET = 8'h01;
	// counting limits
	localparam logic [7:0] CACT_LIMIT   = 8'h40;
	localparam logic [3:0] FULL_PRE_MAX = 4'hf;
	localparam logic [7:0] DIS_PRE_MAX  = 8'hff;
	// discharge rate bounds, whole multiples of C
	localparam logic [7:0] DR_B0 = 8'h01;
	localparam logic [7:0] DR_B1 = 8'h03;
	localparam logic [7:0] DR_B2 = 8'h06;
	localparam logic [7:0] DR_B3 = 8'h09;
	localparam logic [7:0] DR_B4 = 8'h0c;
	localparam logic [2:0] OVERLOAD_FLAG_THR = 3'h3;
	// charge rate bounds in units of C/40: C/8 and C/5
	localparam logic [7:0] CR_B0 = 8'h05;
	localparam logic [7:0] CR_B1 = 8'h08;
	localparam logic [1:0] CR_MID  = 2'h1;
	localparam logic [1:0] CR_HIGH = 2'h3;
	localparam logic [1:0] VQ_INCS = 2'h2;
	typedef enum logic {CAL_IDLE, CAL_RUN} gsr_cal_t;
endpackage

// ---- core/gsr_cmd_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// command word traffic between the bank and the command executor
interface gsr_cmd_if;
	logic       cmd_wr;
	logic [7:0] cmd_data;
	logic       auto_start;
	logic       cal_active;
	logic       cal_done;
	logic       full_reset;
	modport exec (input cmd_wr, cmd_data, auto_start, output cal_active, cal_done, full_reset);
	modport bank (output cmd_wr, cmd_data, auto_start, input cal_active, cal_done, full_reset);
endinterface
`default_nettype wire

// ---- core/gsr_cmd_exec.sv ----
`timescale 1ns/1ps
`default_nettype none
module gsr_cmd_exec (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic cal_ok,
	gsr_cmd_if.exec   cmd
);
	gsr_pkg::gsr_cal_t state_r;
	gsr_pkg::gsr_cal_t state_nxt;
	logic              pwrup_r;
	logic              reset_r;
	logic              done_r;

	wire is_reset = cmd.cmd_wr && (cmd.cmd_data == gsr_pkg::CMD_FULL_RESET);
	wire is_start = cmd.cmd_wr && (cmd.cmd_data == gsr_pkg::CMD_CAL_START);
	wire is_stop  = cmd.cmd_wr && (cmd.cmd_data == gsr_pkg::CMD_CAL_STOP);
	wire go       = is_start || cmd.auto_start || pwrup_r;

	// stop wins over a start in the same cycle, the host asked last
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			gsr_pkg::CAL_IDLE: begin
				if (go && !is_stop) begin
					state_nxt = gsr_pkg::CAL_RUN;
				end
			end
			gsr_pkg::CAL_RUN: begin
				if (is_stop || cal_ok) begin
					state_nxt = gsr_pkg::CAL_IDLE;
				end
			end
			default: state_nxt = gsr_pkg::CAL_IDLE;
		endcase
	end

	// power-up request lasts one cycle after release
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_r <= gsr_pkg::CAL_IDLE;
			pwrup_r <= 1'b1;
			reset_r <= 1'b0;
			done_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			pwrup_r <= 1'b0;
			reset_r <= is_reset;
			done_r  <= (state_r == gsr_pkg::CAL_RUN) && cal_ok && !is_stop;
		end
	end

	assign cmd.cal_active = (state_r == gsr_pkg::CAL_RUN);
	assign cmd.cal_done   = done_r;
	assign cmd.full_reset = reset_r;

	cal_stop_a: assert property (@(posedge mclk) disable iff (!rst_n)
		is_stop |=> !cmd.cal_active) else $error("calibration kept running after stop");
	cov_cal_done: cover property (@(posedge mclk) disable iff (!rst_n) cmd.cal_done);
endmodule
`default_nettype wire

// ---- core/gsr_bank.sv ----
`timescale 1ns/1ps
`default_nettype none
module gsr_bank (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        host_byte_valid,
	input  wire logic [7:0]  host_byte,
	input  wire logic        link_break,
	output logic      [7:0]  rd_data,
	output logic             rd_valid,
	input  wire logic        cell_over,
	input  wire logic        dis_qualified,
	input  wire logic        batt_below_edv,
	input  wire logic [7:0]  temp_deg,
	input  wire logic [7:0]  dis_rate,
	input  wire logic [7:0]  chg_rate,
	input  wire logic [7:0]  cap_sel_level,
	input  wire logic [7:0]  opt_level,
	input  wire logic [15:0] vbat_mv,
	input  wire logic [15:0] vsense_mv,
	input  wire logic [15:0] vtherm_mv,
	input  wire logic        nac_inc,
	input  wire logic        nac_dec,
	input  wire logic        charge_seen,
	input  wire logic        discharge_seen,
	input  wire logic        charge_action,
	input  wire logic        lmd_update,
	input  wire logic [7:0]  lmd_new,
	input  wire logic        dis_count,
	input  wire logic        trickle_seen,
	input  wire logic        cal_ok,
	input  wire logic [4:0]  led_cap,
	output logic      [4:0]  led_out,
	output logic             sense_a_sel,
	output logic             sense_b_sel,
	output logic             cal_active
);
	gsr_cmd_if cmd ();

	logic       wait_data_r;
	logic [6:0] addr_r;
	logic [7:0] rd_data_r;
	logic       rd_valid_r;
	logic [7:0] nac_r;
	logic [7:0] lmd_r;
	logic [7:0] dcap_r;
	logic [7:0] cact_r;
	logic [7:0] ledctl_r;
	logic [7:0] ftally_r;
	logic [7:0] command_word_r;
	logic [7:0] dtally_r;
	logic [3:0] full_pre_r;
	logic [7:0] dis_pre_r;
	logic [1:0] inc_cnt_r;
	logic       full_eq_r;
	logic       dcap_load_r;
	logic       charging_flag_r;
	logic       brp_r;
	logic       mcv_r;
	logic       ci_r;
	logic       vdq_r;
	logic       edv_r;
	logic       oce_r;
	logic       overload_flag_r;
	logic       vq_r;
	logic [2:0] dr_r;
	logic [1:0] cr_r;
	logic [4:0] led_r;
	logic       sns_r;

	gsr_cmd_exec u_exec (
		.mclk   (mclk),
		.rst_n  (rst_n),
		.cal_ok (cal_ok),
		.cmd    (cmd.exec)
	);

	// byte framing: command byte, then a data byte for writes
	// direction and address
	wire       is_cmd   = host_byte_valid && !wait_data_r;
	wire       is_read  = is_cmd && !host_byte[gsr_pkg::CMD_DIR_BIT];
	wire       is_wcmd  = is_cmd && host_byte[gsr_pkg::CMD_DIR_BIT];
	wire       wr_stb   = host_byte_valid && wait_data_r;
	wire [6:0] rd_addr  = host_byte[6:0];
	wire       fres     = cmd.full_reset;

	// write decode
	// absent writes dropped
	wire w_nac    = wr_stb && (addr_r == gsr_pkg::ADDR_NAC);
	wire w_lmd    = wr_stb && (addr_r == gsr_pkg::ADDR_LMD);
	wire w_ledctl = wr_stb && (addr_r == gsr_pkg::ADDR_LEDCTL);
	wire w_ftally = wr_stb && (addr_r == gsr_pkg::ADDR_FTALLY);
	wire w_cmd    = wr_stb && (addr_r == gsr_pkg::ADDR_CMD);
	wire w_dcap   = wr_stb && (addr_r == gsr_pkg::ADDR_DCAP);
	wire wr_hit   = w_nac || w_lmd || w_ledctl || w_ftally || w_cmd || w_dcap;

	wire [2:0] dr_code = (dis_rate <= gsr_pkg::DR_B0) ? 3'h0 :
	                     (dis_rate <= gsr_pkg::DR_B1) ? 3'h1 :
	                     (dis_rate <= gsr_pkg::DR_B2) ? 3'h2 :
	                     (dis_rate <= gsr_pkg::DR_B3) ? 3'h3 :
	                     (dis_rate <= gsr_pkg::DR_B4) ? 3'h4 : 3'h5;
	wire [1:0] cr_code = (chg_rate <= gsr_pkg::CR_B0) ? 2'h0 :
	                     (chg_rate <= gsr_pkg::CR_B1) ? gsr_pkg::CR_MID : gsr_pkg::CR_HIGH;

	// status bytes; reserved bits tie to zero
	wire [7:0] stat1 = {charging_flag_r, brp_r, mcv_r, ci_r, vdq_r, 1'b0, edv_r, oce_r};
	wire [7:0] stat2 = {1'b0, dr_r, 3'h0, overload_flag_r};
	wire [7:0] stat3 = {4'h0, vq_r, cr_r, 1'b0};

	// voltage pairs, low byte at lower address; raw bytes
	wire [7:0] rd_mux =
		(rd_addr == gsr_pkg::ADDR_STAT1)  ? stat1 :
		(rd_addr == gsr_pkg::ADDR_TEMP)   ? temp_deg :
		(rd_addr == gsr_pkg::ADDR_NAC)    ? nac_r :
		(rd_addr == gsr_pkg::ADDR_LMD)    ? lmd_r :
		(rd_addr == gsr_pkg::ADDR_STAT2)  ? stat2 :
		(rd_addr == gsr_pkg::ADDR_CSEL)   ? cap_sel_level :
		(rd_addr == gsr_pkg::ADDR_OPT)    ? opt_level :
		(rd_addr == gsr_pkg::ADDR_CACT)   ? cact_r :
		(rd_addr == gsr_pkg::ADDR_LEDCTL) ? ledctl_r :
		(rd_addr == gsr_pkg::ADDR_FTALLY) ? ftally_r :
		(rd_addr == gsr_pkg::ADDR_CMD)    ? command_word_r :
		(rd_addr == gsr_pkg::ADDR_DCAP)   ? dcap_r :
		(rd_addr == gsr_pkg::ADDR_VBATL)  ? vbat_mv[7:0] :
		(rd_addr == gsr_pkg::ADDR_VBATH)  ? vbat_mv[15:8] :
		(rd_addr == gsr_pkg::ADDR_VSNSL)  ? vsense_mv[7:0] :
		(rd_addr == gsr_pkg::ADDR_VSNSH)  ? vsense_mv[15:8] :
		(rd_addr == gsr_pkg::ADDR_VTHL)   ? vtherm_mv[7:0] :
		(rd_addr == gsr_pkg::ADDR_VTHH)   ? vtherm_mv[15:8] :
		(rd_addr == gsr_pkg::ADDR_DTALLY) ? dtally_r :
		(rd_addr == gsr_pkg::ADDR_STAT3)  ? stat3 : 8'h00;

	// capacity events
	wire full_eq   = (nac_r == lmd_r);
	wire full_rise = full_eq && !full_eq_r;
	wire vdq_rise  = dis_qualified && !vdq_r;
	wire vq_set    = nac_inc && !discharge_seen && (inc_cnt_r == (gsr_pkg::VQ_INCS - 2'h1));

	// command word and self-start requests to the executor
	assign cmd.cmd_wr     = w_cmd;
	assign cmd.cmd_data   = host_byte;
	assign cmd.auto_start = trickle_seen || full_rise;

	// host framing; a break drops a half-received write
	always_ff @(posedge mclk) begin
		if (!rst_n || link_break) begin
			wait_data_r <= 1'b0;
			addr_r      <= 7'h00;
		end else if (host_byte_valid) begin
			wait_data_r <= is_wcmd;
			addr_r      <= host_byte[6:0];
		end
	end

	// read answer one cycle after the command byte; absent address reads zero
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rd_data_r  <= 8'h00;
			rd_valid_r <= 1'b0;
		end else begin
			rd_valid_r <= is_read;
			if (is_read) begin
				rd_data_r <= rd_mux;
			end
		end
	end

	// remaining capacity, compensated increments come from outside
	always_ff @(posedge mclk) begin
		if (!rst_n || fres) begin
			nac_r <= 8'h00;
		end else if (w_nac) begin
			nac_r <= host_byte;
		end else if (nac_inc && !nac_dec && nac_r != lmd_r) begin
			nac_r <= nac_r + 8'h01;
		end else if (nac_dec && !nac_inc && nac_r != 8'h00) begin
			nac_r <= nac_r - 8'h01;
		end
	end

	// design capacity caught from the select pin after release
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			dcap_r      <= 8'h00;
			dcap_load_r <= 1'b1;
		end else begin
			dcap_load_r <= 1'b0;
			if (w_dcap) begin
				dcap_r <= host_byte;
			end else if (dcap_load_r) begin
				dcap_r <= cap_sel_level;
			end
		end
	end

	// learned capacity reloads from design capacity
	always_ff @(posedge mclk) begin
		if (!rst_n || dcap_load_r) begin
			lmd_r <= dcap_load_r ? cap_sel_level : 8'h00;
		end else if (fres) begin
			lmd_r <= dcap_r;
		end else if (w_lmd) begin
			lmd_r <= host_byte;
		end else if (lmd_update) begin
			lmd_r <= lmd_new;
		end
	end

	// charge actions, saturating so the count never wraps below the limit
	always_ff @(posedge mclk) begin
		if (!rst_n || fres || lmd_update) begin
			cact_r <= 8'h00;
		end else if (charge_action && cact_r != 8'hff) begin
			cact_r <= cact_r + 8'h01;
		end
	end

	// full charge prescaler, one tally step per sixteen events
	always_ff @(posedge mclk) begin
		if (!rst_n || fres) begin
			full_pre_r <= 4'h0;
			ftally_r   <= 8'h00;
			full_eq_r  <= 1'b1;
		end else begin
			full_eq_r <= full_eq;
			if (w_ftally) begin
				ftally_r <= host_byte;
			end else if (full_rise && full_pre_r == gsr_pkg::FULL_PRE_MAX) begin
				ftally_r <= ftally_r + 8'h01;
			end
			if (full_rise) begin
				full_pre_r <= full_pre_r + 4'h1;
			end
		end
	end

	// discharge tally restarts when qualification begins
	always_ff @(posedge mclk) begin
		if (!rst_n || fres || vdq_rise) begin
			dis_pre_r <= 8'h00;
			dtally_r  <= 8'h00;
		end else if (vdq_r && dis_count) begin
			dis_pre_r <= dis_pre_r + 8'h01;
			if (dis_pre_r == gsr_pkg::DIS_PRE_MAX) begin
				dtally_r <= dtally_r + 8'h01;
			end
		end
	end

	// two increments make a valid charge; discharge starts over
	always_ff @(posedge mclk) begin
		if (!rst_n || discharge_seen) begin
			inc_cnt_r <= 2'h0;
			vq_r      <= 1'b0;
		end else if (vq_set) begin
			inc_cnt_r <= gsr_pkg::VQ_INCS;
			vq_r      <= 1'b1;
		end else if (nac_inc && inc_cnt_r != gsr_pkg::VQ_INCS) begin
			inc_cnt_r <= inc_cnt_r + 2'h1;
		end
	end

	// level flags
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			mcv_r <= 1'b0;
			vdq_r <= 1'b0;
			dr_r  <= 3'h0;
			cr_r  <= 2'h0;
		end else begin
			mcv_r <= cell_over;
			vdq_r <= dis_qualified;
			dr_r  <= dr_code;
			cr_r  <= cr_code;
		end
	end

	// overload holds its value when rate sits at the threshold
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			overload_flag_r <= 1'b0;
		end else if (dr_code > gsr_pkg::OVERLOAD_FLAG_THR) begin
			overload_flag_r <= 1'b1;
		end else if (dr_code < gsr_pkg::OVERLOAD_FLAG_THR) begin
			overload_flag_r <= 1'b0;
		end
	end

	// sticky flags: the set term is tested first so it wins
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ci_r   <= 1'b1;
			edv_r  <= 1'b0;
			oce_r  <= 1'b0;
			charging_flag_r <= 1'b0;
			brp_r  <= 1'b0;
		end else begin
			ci_r   <= (fres || cact_r > gsr_pkg::CACT_LIMIT) ? 1'b1 : (lmd_update ? 1'b0 : ci_r);
			edv_r  <= batt_below_edv ? 1'b1 : (vq_set ? 1'b0 : edv_r);
			oce_r  <= cmd.cal_done ? 1'b1 : oce_r;
			charging_flag_r <= charge_seen ? 1'b1 : (discharge_seen ? 1'b0 : charging_flag_r);
			brp_r  <= fres ? 1'b1 : brp_r;
		end
	end

	// led control keeps only implemented bits
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ledctl_r <= gsr_pkg::LED_CTL_RESET;
			command_word_r  <= 8'h00;
		end else begin
			if (w_ledctl) begin
				ledctl_r <= host_byte & gsr_pkg::LED_CTL_MASK;
			end
			if (w_cmd) begin
				command_word_r <= host_byte;
			end
		end
	end

	// override path; dark LEDs and open sense inputs while calibrating
	wire [4:0] led_nxt = cmd.cal_active ? 5'h00 :
	                     (!ledctl_r[gsr_pkg::LED_EN_BIT] ? ledctl_r[5:1] : led_cap);
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			led_r <= 5'h00;
			sns_r <= 1'b1;
		end else begin
			led_r <= led_nxt;
			sns_r <= !cmd.cal_active;
		end
	end

	assign rd_data     = rd_data_r;
	assign rd_valid    = rd_valid_r;
	assign led_out     = led_r;
	assign sense_a_sel = sns_r;
	assign sense_b_sel = sns_r;
	assign cal_active  = cmd.cal_active;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	cell_ov_a: assert property (cell_over |=> mcv_r) else $error("overvoltage flag missed");
	ci_clear_a: assert property (lmd_update && !fres && cact_r <= gsr_pkg::CACT_LIMIT |=> !ci_r)
		else $error("inaccurate flag not cleared on update");
	edv_latch_a: assert property (batt_below_edv ##1 !vq_set |=> edv_r) else $error("edv not latched");
	oce_set_a: assert property (cmd.cal_done |=> oce_r) else $error("cal done flag missing");
	overload_flag_flag_a: assert property (dr_code > gsr_pkg::OVERLOAD_FLAG_THR |=> overload_flag_r) else $error("overload missed");
	led_force_a: assert property (!cmd.cal_active && !ledctl_r[0] |=> led_out == $past(ledctl_r[5:1]))
		else $error("led override not applied");
	full_rst_a: assert property (fres |=> nac_r == 8'h00 && cact_r == 8'h00 && ftally_r == 8'h00
		&& dtally_r == 8'h00 && lmd_r == $past(dcap_r) && brp_r) else $error("full reset incomplete");
	cal_dark_a: assert property (cmd.cal_active |=> led_out == 5'h00 && !sense_a_sel && !sense_b_sel)
		else $error("leds or sense active during calibration");
	vq_set_a: assert property (nac_inc && inc_cnt_r == 2'h1 && !discharge_seen |=> vq_r)
		else $error("valid charge missed");
	// back-to-back reads are legal, so only the answer edge and its data are checked
	rd_ans_a: assert property (is_read |=> rd_valid && rd_data == $past(rd_mux))
		else $error("read answer timing");
	bad_wr_a: assert property (wr_stb && !wr_hit |=> $stable(ledctl_r) && $stable(command_word_r))
		else $error("absent address write took effect");

	cov_read: cover property (is_read ##1 rd_valid);
	cov_fres: cover property (fres);
	cov_vq: cover property (nac_inc ##[1:20] vq_set);
endmodule
`default_nettype wire

// ---- verification/gsr_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// host side of the register link, byte level only
module gsr_host_model (
	input  wire logic       mclk,
	input  wire logic [7:0] rd_data,
	input  wire logic       rd_valid,
	output var logic        host_byte_valid,
	output var logic [7:0]  host_byte,
	output var logic        link_break
);
	// line starts idle, no byte offered
	initial begin
		host_byte_valid = 1'b0;
		host_byte = 8'h00;
		link_break = 1'b0;
	end
	// one byte strobe; afterwards the line shows the inverse, never a stale copy
	task automatic send(input logic [7:0] b);
		@(posedge mclk);
		host_byte_valid <= 1'b1;
		host_byte <= b;
		@(posedge mclk);
		host_byte_valid <= 1'b0;
		host_byte <= ~b;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic slow);
		if (slow) begin
			send({1'b1, a});
			repeat (3) @(posedge mclk);
			send(d);
		end else begin
			@(posedge mclk);
			host_byte_valid <= 1'b1;
			host_byte <= {1'b1, a};
			send(d);
		end
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ok);
		send({1'b0, a});
		ok = 1'b0;
		d = 8'h00;
		// answer is a one-cycle pulse, so look at every edge
		for (int i = 0; i < 4 && !ok; i++) begin
			@(posedge mclk);
			if (rd_valid === 1'b1) begin
				ok = 1'b1;
				d = rd_data;
			end
		end
	endtask
	task automatic cmd(input logic [7:0] c);
		wr(gsr_pkg::ADDR_CMD, c, 1'b0);
	endtask
	// framer drops a half-received write
	task automatic brk;
		@(posedge mclk);
		link_break <= 1'b1;
		@(posedge mclk);
		link_break <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct packed {
		logic [7:0] dr;
		logic [7:0] cr;
		logic [6:0] a;
		logic [7:0] e;
	} gsr_row_t;
	logic        mclk = 1'b0, rst_n = 1'b0, cell_over = 1'b0, dis_qualified = 1'b0;
	logic        batt_below_edv = 1'b0, host_byte_valid, link_break, rd_valid;
	logic        sense_a_sel, sense_b_sel, cal_active;
	logic [7:0]  temp_deg = 8'hf6, dis_rate = 8'h00, chg_rate = 8'h00, opt_level = 8'h3c;
	logic [7:0]  lmd_new = 8'h00, host_byte, rd_data, cap_sel_level = 8'h80;
	logic [15:0] vbat_mv = 16'h1234, vsense_mv = 16'h5678, vtherm_mv = 16'h9abc;
	logic [8:0]  pls = 9'h000;
	logic [4:0]  led_cap = 5'h0a, led_out;
	int          n_errors = 0, tests_run = 0;
	gsr_row_t    rows [25];

	always #20 mclk = ~mclk;

	// pulse inputs share one vector so a single task drives them all
	gsr_bank u_gsr_bank (
		.mclk, .rst_n, .host_byte_valid, .host_byte, .link_break, .rd_data, .rd_valid,
		.cell_over, .dis_qualified, .batt_below_edv, .temp_deg, .dis_rate, .chg_rate,
		.cap_sel_level, .opt_level, .vbat_mv, .vsense_mv,
		.vtherm_mv, .nac_inc(pls[0]), .nac_dec(pls[1]), .charge_seen(pls[2]),
		.discharge_seen(pls[3]), .charge_action(pls[4]), .lmd_update(pls[5]), .lmd_new,
		.dis_count(pls[6]), .trickle_seen(pls[7]), .cal_ok(pls[8]), .led_cap, .led_out,
		.sense_a_sel, .sense_b_sel, .cal_active
	);
	gsr_host_model u_host (.mclk, .rd_data, .rd_valid, .host_byte_valid, .host_byte, .link_break);

	task automatic summarize;
		if (n_errors == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// masked register read; a missing answer ends the run
	task automatic chk(input logic [6:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] d;
		logic       ok;
		u_host.rd(a, d, ok);
		if (!ok) begin
			n_errors++;
			summarize();
		end
		cmp({8'h00, d & m}, {8'h00, e});
	endtask
	task automatic pulse(input logic [8:0] m, input int n);
		repeat (n) begin
			@(posedge mclk);
			pls <= m;
			@(posedge mclk);
			pls <= 9'h000;
		end
	endtask
	// registered outputs need a few edges to follow
	task automatic settle;
		repeat (3) @(posedge mclk);
		#1;
	endtask
	task automatic do_reset;
		rst_n <= 1'b0;
		repeat (16) @(posedge mclk);
		cmp({10'h000, rd_valid, led_out}, 16'h0000);
		rst_n <= 1'b1;
	endtask

	// watchdog: a hang is a failure
	initial begin
		repeat (40000) @(posedge mclk);
		n_errors++;
		summarize();
	end

	initial begin
		rows = '{
			'{8'h01, 8'h00, 7'h06, 8'h00}, '{8'h02, 8'h00, 7'h06, 8'h10},
			'{8'h03, 8'h00, 7'h06, 8'h10}, '{8'h06, 8'h00, 7'h06, 8'h20},
			'{8'h09, 8'h00, 7'h06, 8'h30}, '{8'h0c, 8'h00, 7'h06, 8'h41},
			'{8'h09, 8'h00, 7'h06, 8'h31}, '{8'h0d, 8'h00, 7'h06, 8'h51},
			'{8'h04, 8'h00, 7'h06, 8'h20}, '{8'h00, 8'h05, 7'h4c, 8'h00},
			'{8'h00, 8'h06, 7'h4c, 8'h02}, '{8'h00, 8'h08, 7'h4c, 8'h02},
			'{8'h00, 8'h09, 7'h4c, 8'h06}, '{8'h00, 8'h00, 7'h02, 8'hf6},
			'{8'h00, 8'h00, 7'h07, 8'h80}, '{8'h00, 8'h00, 7'h08, 8'h3c},
			'{8'h00, 8'h00, 7'h10, 8'h34}, '{8'h00, 8'h00, 7'h11, 8'h12},
			'{8'h00, 8'h00, 7'h12, 8'h78}, '{8'h00, 8'h00, 7'h13, 8'h56},
			'{8'h00, 8'h00, 7'h14, 8'hbc}, '{8'h00, 8'h00, 7'h15, 8'h9a},
			'{8'h00, 8'h00, 7'h04, 8'h00}, '{8'h00, 8'h00, 7'h7f, 8'h00},
			'{8'h00, 8'h00, 7'h0f, 8'h80}
		};
		do_reset();
		settle();
		cmp({8'h00, cal_active, sense_a_sel, sense_b_sel, led_out}, 16'h0080);
		chk(7'h01, 8'h51, 8'h10);
		chk(7'h05, 8'hff, 8'h80);
		chk(7'h0a, 8'hff, 8'h01);
		pulse(9'h100, 1);
		settle();
		cmp({13'h0000, cal_active, sense_a_sel, sense_b_sel}, 16'h0003);
		chk(7'h01, 8'h01, 8'h01);
		// rate codes and measured values, one read per row
		foreach (rows[i]) begin
			@(posedge mclk);
			dis_rate <= rows[i].dr;
			chg_rate <= rows[i].cr;
			repeat (2) @(posedge mclk);
			chk(rows[i].a, 8'hff, rows[i].e);
		end
		// read-only, absent and reserved places
		u_host.wr(7'h02, 8'h11, 1'b0);
		chk(7'h02, 8'hff, 8'hf6);
		u_host.wr(7'h04, 8'h55, 1'b0);
		chk(7'h04, 8'hff, 8'h00);
		u_host.wr(7'h0a, 8'hff, 1'b0);
		chk(7'h0a, 8'hff, 8'h3f);
		led_cap <= 5'h11;
		settle();
		cmp({11'h000, led_out}, {11'h000, led_cap});
		u_host.wr(7'h0a, 8'h2a, 1'b1);
		chk(7'h0a, 8'hff, 8'h2a);
		settle();
		cmp({11'h000, led_out}, 16'h0015);
		@(posedge mclk);
		temp_deg <= 8'h19;
		opt_level <= 8'hc3;
		vbat_mv <= 16'hfe01;
		vsense_mv <= 16'h0203;
		vtherm_mv <= 16'h0405;
		chk(7'h02, 8'hff, 8'h19);
		chk(7'h08, 8'hff, 8'hc3);
		chk(7'h11, 8'hff, 8'hfe);
		chk(7'h12, 8'hff, 8'h03);
		chk(7'h15, 8'hff, 8'h04);
		// commanded calibration start and stop
		u_host.cmd(8'h68);
		settle();
		cmp({8'h00, cal_active, sense_a_sel, sense_b_sel, led_out}, 16'h0080);
		u_host.cmd(8'h60);
		settle();
		cmp({15'h0000, cal_active}, 16'h0000);
		chk(7'h0c, 8'hff, 8'h60);
		// a break drops the pending write; next byte is a command
		u_host.wr(7'h03, 8'h20, 1'b0);
		u_host.send(8'h83);
		u_host.brk();
		chk(7'h03, 8'hff, 8'h20);
		// charge action count around its limit of 64
		@(posedge mclk);
		lmd_new <= 8'h70;
		pulse(9'h020, 1);
		chk(7'h01, 8'h10, 8'h00);
		chk(7'h05, 8'hff, 8'h70);
		pulse(9'h010, 64);
		chk(7'h01, 8'h10, 8'h00);
		pulse(9'h010, 1);
		chk(7'h09, 8'hff, 8'h41);
		chk(7'h01, 8'h10, 8'h10);
		pulse(9'h020, 1);
		chk(7'h09, 8'hff, 8'h00);
		// sixteen charges to full advance the tally once
		u_host.wr(7'h03, 8'h6f, 1'b0);
		pulse(9'h008, 1);
		for (int i = 0; i < 15; i++) begin
			pulse(9'h001, 1);
			pulse(9'h002, 1);
		end
		chk(7'h0b, 8'hff, 8'h00);
		cmp({15'h0000, cal_active}, 16'h0001);
		pulse(9'h001, 1);
		chk(7'h0b, 8'hff, 8'h01);
		chk(7'h4c, 8'h08, 8'h08);
		// discharge, then a below-edv pulse latches end-of-discharge until a valid charge
		pulse(9'h008, 1);
		chk(7'h01, 8'h80, 8'h00);
		chk(7'h4c, 8'h08, 8'h00);
		@(posedge mclk);
		batt_below_edv <= 1'b1;
		@(posedge mclk);
		batt_below_edv <= 1'b0;
		chk(7'h01, 8'h02, 8'h02);
		pulse(9'h002, 2);
		pulse(9'h001, 1);
		chk(7'h01, 8'h02, 8'h02);
		pulse(9'h001, 1);
		chk(7'h01, 8'h02, 8'h00);
		pulse(9'h004, 1);
		chk(7'h01, 8'h80, 8'h80);
		// level flags and the discharge tally prescaler
		@(posedge mclk);
		cell_over <= 1'b1;
		dis_qualified <= 1'b1;
		chk(7'h01, 8'h28, 8'h28);
		pulse(9'h040, 256);
		chk(7'h18, 8'hff, 8'h01);
		@(posedge mclk);
		cell_over <= 1'b0;
		dis_qualified <= 1'b0;
		chk(7'h01, 8'h28, 8'h00);
		u_host.cmd(8'h60);
		pulse(9'h080, 1);
		settle();
		cmp({15'h0000, cal_active}, 16'h0001);
		u_host.cmd(8'h60);
		// full reset through the command word
		u_host.wr(7'h0b, 8'h05, 1'b0);
		chk(7'h0b, 8'hff, 8'h05);
		u_host.cmd(8'h78);
		settle();
		chk(7'h03, 8'hff, 8'h00);
		chk(7'h09, 8'hff, 8'h00);
		chk(7'h0b, 8'hff, 8'h00);
		chk(7'h18, 8'hff, 8'h00);
		chk(7'h05, 8'hff, 8'h80);
		chk(7'h01, 8'h50, 8'h50);
		// second reset in mid-run
		u_host.wr(7'h0a, 8'h2a, 1'b0);
		cap_sel_level <= 8'h60;
		do_reset();
		chk(7'h0a, 8'hff, 8'h01);
		chk(7'h01, 8'h51, 8'h10);
		chk(7'h0f, 8'hff, 8'h60);
		chk(7'h05, 8'hff, 8'h60);
		cmp({15'h0000, cal_active}, 16'h0001);
		summarize();
	end
endmodule
`default_nettype wire
